// ---- design/lbm_params.svh ----
`ifndef LBM_PARAMS_SVH
`define LBM_PARAMS_SVH

// clock period in picoseconds
`define LBM_CLK_PS            4000
// timing figures in ns or us as specified
`define LBM_ACTIVE_MIN_NS     200
`define LBM_ACTIVE_MAX_NS     10000
`define LBM_RECOVERY_NS       200
`define LBM_CYCLE_NS          400
`define LBM_SEL_TO_RISE_NS    200
`define LBM_STROBE_LOW_NS     80
`define LBM_PWRUP_US          100
`define LBM_PWRDN_US          0
// derived cycle counts: minimums round up, maximums round down
`define LBM_CEIL_CYC(ns)      (((ns) * 1000 + `LBM_CLK_PS - 1) / `LBM_CLK_PS)
`define LBM_FLOOR_CYC(ns)     (((ns) * 1000) / `LBM_CLK_PS)
`define LBM_ACTIVE_MIN_CYC    `LBM_CEIL_CYC(`LBM_ACTIVE_MIN_NS)
`define LBM_ACTIVE_MAX_CYC    `LBM_FLOOR_CYC(`LBM_ACTIVE_MAX_NS)
`define LBM_RECOVERY_CYC      `LBM_CEIL_CYC(`LBM_RECOVERY_NS)
`define LBM_SEL_TO_RISE_CYC   `LBM_CEIL_CYC(`LBM_SEL_TO_RISE_NS)
`define LBM_STROBE_LOW_CYC    `LBM_CEIL_CYC(`LBM_STROBE_LOW_NS)
`define LBM_PWRUP_CYC         `LBM_CEIL_CYC(`LBM_PWRUP_US * 1000)
// widths
`define LBM_ADDR_W            9
`define LBM_DATA_W            8
`define LBM_CNT_W             16

`endif

// ---- design/lbm_pkg.sv ----
package lbm_pkg;
    typedef enum logic [2:0] {
        LBM_ST_PWRUP   = 3'b000,
        LBM_ST_IDLE    = 3'b001,
        LBM_ST_ACTIVE  = 3'b010,
        LBM_ST_RECOVER = 3'b011,
        LBM_ST_OFF     = 3'b100
    } lbm_state_t;
endpackage

// ---- design/lbm_sync.sv ----
`timescale 1ns/1ps
`include "lbm_params.svh"

// two-flop synchroniser for pin inputs
module lbm_sync #(
    parameter int W = 8
) (
    input  wire logic         clk_sys,   // system clock
    input  wire logic         rst,       // sync reset
    input  wire logic [W-1:0] d_async,   // asynchronous input
    output logic      [W-1:0] q_sync     // synchronised output
);
    logic [W-1:0] meta_ff;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            meta_ff <= '0;
            q_sync  <= '0;
        end else begin
            meta_ff <= d_async;
            q_sync  <= meta_ff;
        end
    end
endmodule

// ---- design/lbm_host.sv ----
`timescale 1ns/1ps
`include "lbm_params.svh"

module lbm_host #(
    parameter int PWRUP_CYC = `LBM_PWRUP_CYC,    // supply-stable wait
    parameter bit SEL_CTRL  = 1'b1               // 1: select-controlled writes
) (
    input  wire logic                     clk_sys,       // 250 MHz clock
    input  wire logic                     rst,           // sync reset, active high
    input  wire logic                     supply_ok,     // supply above 4.5V
    input  wire logic                     pwr_down_req,  // request to remove supply
    input  wire logic                     req_valid,     // access request
    input  wire logic                     req_write,     // 1 write, 0 read
    input  wire logic [`LBM_ADDR_W-1:0]   req_addr,      // byte address
    input  wire logic [`LBM_DATA_W-1:0]   req_wdata,     // write data
    output logic                          req_ready,     // request accepted
    output logic                          rsp_valid,     // access done pulse
    output logic      [`LBM_DATA_W-1:0]   rsp_rdata,     // read data
    output logic                          pwr_down_ok,   // safe to remove supply
    output logic                          sel_n,         // chip select, active low
    output logic                          strobe_n,      // write strobe, active low
    output logic                          gate_n,        // output gate, active low
    output logic      [`LBM_ADDR_W-1:0]   addr_lines,    // address pins
    output logic      [`LBM_DATA_W-1:0]   data_lines_o,  // data pins out
    output logic                          data_lines_oe, // high while driving data
    input  wire logic [`LBM_DATA_W-1:0]   data_lines_i   // data pins in
);
    localparam int CW = `LBM_CNT_W;

    // =====================================================
    // input synchronisers
    // =====================================================
    logic [`LBM_DATA_W+1:0] sync_q;
    lbm_sync #(.W(`LBM_DATA_W + 2)) u_sync (
        .clk_sys (clk_sys),
        .rst     (rst),
        .d_async ({supply_ok, pwr_down_req, data_lines_i}),
        .q_sync  (sync_q)
    );
    wire                    supply_s = sync_q[`LBM_DATA_W+1];
    wire                    pdreq_s  = sync_q[`LBM_DATA_W];
    wire [`LBM_DATA_W-1:0]  rdata_s  = sync_q[`LBM_DATA_W-1:0];

    // =====================================================
    // state and counters
    // =====================================================
    lbm_pkg::lbm_state_t state_ff, nxt_state;
    logic [CW-1:0]       cnt_ff, nxt_cnt;
    logic                wr_ff;

    localparam logic [CW-1:0] ACT_LAST = CW'(`LBM_ACTIVE_MIN_CYC - 1);
    localparam logic [CW-1:0] REC_LAST = CW'(`LBM_RECOVERY_CYC - 1);
    localparam logic [CW-1:0] PU_LAST  = CW'(PWRUP_CYC - 1);
    // strobe low span ends with select rise, so strobe-controlled start
    localparam logic [CW-1:0] WP_START = CW'(`LBM_ACTIVE_MIN_CYC - `LBM_STROBE_LOW_CYC - 2);

    wire act_done  = (state_ff == lbm_pkg::LBM_ST_ACTIVE)  && (cnt_ff == ACT_LAST);
    wire rec_done  = (state_ff == lbm_pkg::LBM_ST_RECOVER) && (cnt_ff == REC_LAST);
    wire pu_done   = (state_ff == lbm_pkg::LBM_ST_PWRUP)   && (cnt_ff == PU_LAST);
    wire idle      = (state_ff == lbm_pkg::LBM_ST_IDLE);
    wire start     = idle && req_valid && !pdreq_s;
    wire go_off    = idle && pdreq_s;

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff + CW'(1);
        case (state_ff)
            lbm_pkg::LBM_ST_PWRUP: begin
                if (!supply_s) begin
                    nxt_cnt = '0;
                end else if (pu_done) begin
                    nxt_state = lbm_pkg::LBM_ST_IDLE;
                    nxt_cnt   = '0;
                end
            end
            lbm_pkg::LBM_ST_IDLE: begin
                nxt_cnt = '0;
                if (go_off) begin
                    nxt_state = lbm_pkg::LBM_ST_OFF;
                end else if (start) begin
                    nxt_state = lbm_pkg::LBM_ST_ACTIVE;
                end
            end
            lbm_pkg::LBM_ST_ACTIVE: begin
                if (act_done) begin
                    nxt_state = lbm_pkg::LBM_ST_RECOVER;
                    nxt_cnt   = '0;
                end
            end
            lbm_pkg::LBM_ST_RECOVER: begin
                if (rec_done) begin
                    nxt_state = lbm_pkg::LBM_ST_IDLE;
                    nxt_cnt   = '0;
                end
            end
            // parked until supply drops, then back to the power-up wait
            lbm_pkg::LBM_ST_OFF: begin
                nxt_cnt = '0;
                if (!supply_s) begin
                    nxt_state = lbm_pkg::LBM_ST_PWRUP;
                end
            end
            default: begin
                nxt_state = lbm_pkg::LBM_ST_PWRUP;
                nxt_cnt   = '0;
            end
        endcase
    end

    // =====================================================
    // pin drive
    // =====================================================
    wire in_act  = (nxt_state == lbm_pkg::LBM_ST_ACTIVE);
    wire nxt_wr  = start ? req_write : wr_ff;
    // select-controlled: strobe low with select; else late strobe fall
    // strobe rises with select after 200 ns of select
    wire strobe_on = in_act && nxt_wr && (SEL_CTRL || (!start && cnt_ff >= WP_START));
    // hold the gate high during writes to avoid bus fights
    wire gate_on   = in_act && !nxt_wr;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_ff <= lbm_pkg::LBM_ST_PWRUP;
            cnt_ff   <= '0;
            wr_ff    <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            wr_ff    <= nxt_wr;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sel_n         <= 1'b1;
            strobe_n      <= 1'b1;
            gate_n        <= 1'b1;
            data_lines_oe <= 1'b0;
        end else begin
            sel_n         <= !in_act;
            strobe_n      <= !strobe_on;
            gate_n        <= !gate_on;
            data_lines_oe <= in_act && nxt_wr;
        end
    end

    // address and data set up with select fall and held all cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            addr_lines   <= '0;
            data_lines_o <= '0;
        end else if (start) begin
            addr_lines   <= req_addr;
            data_lines_o <= req_wdata;
        end
    end

    // =====================================================
    // request answer
    // =====================================================
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            req_ready   <= 1'b0;
            rsp_valid   <= 1'b0;
            rsp_rdata   <= '0;
            pwr_down_ok <= 1'b0;
        end else begin
            req_ready   <= start;
            rsp_valid   <= act_done;
            pwr_down_ok <= (nxt_state == lbm_pkg::LBM_ST_OFF);
            if (act_done && !wr_ff) begin
                rsp_rdata <= rdata_s;
            end
        end
    end

    // =====================================================
    // checks
    // =====================================================
    int unsigned sel_lo_cnt;
    int unsigned sel_hi_cnt;
    // strobe low run length, for the pulse width check
    int unsigned strobe_lo_cnt;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sel_lo_cnt    <= 0;
            sel_hi_cnt    <= 0;
            strobe_lo_cnt <= 0;
        end else begin
            sel_lo_cnt    <= sel_n ? 0 : sel_lo_cnt + 1;
            sel_hi_cnt    <= sel_n ? sel_hi_cnt + 1 : 0;
            strobe_lo_cnt <= strobe_n ? 0 : strobe_lo_cnt + 1;
        end
    end

    chk_sel_active_time: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(sel_n) |-> ($past(sel_lo_cnt) >= `LBM_ACTIVE_MIN_CYC - 1
                          && $past(sel_lo_cnt) <= `LBM_ACTIVE_MAX_CYC))
        else $error("select active time out of window");

    chk_recovery_time: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(sel_n) |-> $past(sel_hi_cnt) >= `LBM_RECOVERY_CYC - 1)
        else $error("recovery interval too short");

    chk_strobe_in_select: assert property (@(posedge clk_sys) disable iff (rst)
        !strobe_n |-> !sel_n)
        else $error("strobe low outside select");

    chk_strobe_low_width: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(strobe_n) |-> $past(strobe_lo_cnt) >= `LBM_STROBE_LOW_CYC - 1)
        else $error("strobe low too short");

    chk_strobe_rise_late: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(strobe_n) |-> $past(sel_lo_cnt) >= `LBM_SEL_TO_RISE_CYC - 1)
        else $error("strobe rose too early after select");

    chk_no_early_access: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(sel_n) |-> $past(state_ff) == lbm_pkg::LBM_ST_IDLE)
        else $error("access before power-up wait");

    chk_pwrdn_quiet: assert property (@(posedge clk_sys) disable iff (rst)
        pwr_down_ok |-> sel_n && sel_hi_cnt >= `LBM_RECOVERY_CYC)
        else $error("power-down granted mid access");

    chk_gate_in_write: assert property (@(posedge clk_sys) disable iff (rst)
        !strobe_n |-> gate_n && data_lines_oe)
        else $error("gate low or data idle during write");

    cov_read:  cover property (@(posedge clk_sys) disable iff (rst) $rose(sel_n) && !$past(data_lines_oe));
    cov_write: cover property (@(posedge clk_sys) disable iff (rst) $rose(strobe_n));
    cov_pdown: cover property (@(posedge clk_sys) disable iff (rst) $rose(pwr_down_ok));
    cov_late_strobe: cover property (@(posedge clk_sys) disable iff (rst) $fell(strobe_n) && !sel_n && !$fell(sel_n));
endmodule

// ---- test/lbm_mem_model.sv ----
`timescale 1ns/1ps
`include "lbm_params.svh"
// ==========
// byte memory model with latched address
module lbm_mem_model #(
    parameter real ACC_NS   = 100.0, // read data delay after select fall
    parameter real PWRUP_NS = 200.0  // supply-stable wait before first access
) (
    input  wire logic                   sel_n,      // chip select, active low
    input  wire logic                   strobe_n,   // write strobe, active low
    input  wire logic                   gate_n,     // output gate, active low
    input  wire logic                   supply_ok,  // supply above threshold
    input  wire logic [`LBM_ADDR_W-1:0] addr_lines, // address pins
    input  wire logic [`LBM_DATA_W-1:0] data_lines, // resolved data bus
    output logic      [`LBM_DATA_W-1:0] mem_o,      // read data out
    output wire logic                   mem_oe,     // high while driving
    output int                          n_viol      // protocol faults seen
);
    logic [`LBM_DATA_W-1:0] mem [0:511];
    logic [`LBM_ADDR_W-1:0] lat_addr;
    logic [`LBM_DATA_W-1:0] bus_prev;
    logic                   wr, live, rd_ok, done;
    realtime                t_fall, t_rise, t_stb, t_up;
    // value just before an edge, the host may release at the same instant
    assign #1 bus_prev = data_lines;
    assign mem_oe = rd_ok && !sel_n && !gate_n;
    initial begin
        n_viol = 0;
        live = 1'b0;
        rd_ok = 1'b0;
        t_stb = -1000.0;
        t_up = 0.0;
        for (int i = 0; i < 512; i++) mem[i] = 8'h00;
    end
    always @(posedge supply_ok) t_up = $realtime;
    always @(negedge supply_ok) if ($realtime > 0.0 && (!sel_n || $realtime - t_rise < `LBM_RECOVERY_NS)) n_viol++;
    always @(negedge sel_n) begin
        t_fall = $realtime;
        if (!supply_ok || $realtime - t_up < PWRUP_NS || $realtime - t_rise < `LBM_RECOVERY_NS) begin
            n_viol++;
        end else begin
            #1;
            live = 1'b1;
            done = 1'b0;
            lat_addr = addr_lines;
            wr = !strobe_n;
            if (!wr) begin
                #(ACC_NS - 1.0);
                if (live && !wr) begin
                    mem_o = mem[lat_addr];
                    rd_ok = 1'b1;
                end
            end
        end
    end
    always @(negedge strobe_n) begin
        t_stb = $realtime;
        if (!sel_n && live) wr = 1'b1;
        if (!sel_n && live) rd_ok = 1'b0;
    end
    always @(posedge strobe_n) begin
        if (live && !sel_n && $realtime - t_fall < `LBM_SEL_TO_RISE_NS) n_viol++;
        if (live && $realtime - t_stb < `LBM_STROBE_LOW_NS) n_viol++;
        take_data();
    end
    always @(posedge sel_n) begin
        if (live && ($realtime - t_fall < `LBM_ACTIVE_MIN_NS || $realtime - t_fall > `LBM_ACTIVE_MAX_NS)) n_viol++;
        take_data();
        live = 1'b0;
        rd_ok = 1'b0;
        t_rise = $realtime;
    end
    task take_data();
        if (live && wr && !done) mem[lat_addr] = bus_prev;
        if (live && wr) done = 1'b1;
    endtask
endmodule

// ---- test/lbm_host_tb.sv ----
`timescale 1ns/1ps
`include "lbm_params.svh"
// ==========
// bench for the memory-port host
module lbm_host_tb;
    localparam int PWRUP_CYC = 50;
    logic                   clk_sys, rst, supply_ok, pwr_down_req, req_valid, req_write;
    logic                   req_ready, rsp_valid, pwr_down_ok, sel_n, strobe_n, gate_n, data_lines_oe;
    logic                   sel_n_b, strobe_n_b, gate_n_b, data_lines_oe_b;
    logic [`LBM_ADDR_W-1:0] req_addr, addr_lines, addr_lines_b;
    logic [`LBM_DATA_W-1:0] req_wdata, rsp_rdata, data_lines_o, mem_o, float_pat;
    logic [`LBM_DATA_W-1:0] rsp_rdata_b, data_lines_o_b, mem_o_b;
    wire                    mem_oe, mem_oe_b;
    wire  [`LBM_DATA_W-1:0] data_bus, data_bus_b;
    int                     n_fail, tests_run, n_viol, n_viol_b;
    // floating bus shows a moving pattern
    assign data_bus = data_lines_oe ? data_lines_o : (mem_oe ? mem_o : float_pat);
    assign data_bus_b = data_lines_oe_b ? data_lines_o_b : (mem_oe_b ? mem_o_b : float_pat);
    lbm_host #(.PWRUP_CYC(PWRUP_CYC), .SEL_CTRL(1'b1)) DUT (
        .clk_sys, .rst, .supply_ok, .pwr_down_req, .req_valid, .req_write, .req_addr, .req_wdata,
        .req_ready, .rsp_valid, .rsp_rdata, .pwr_down_ok, .sel_n, .strobe_n, .gate_n, .addr_lines,
        .data_lines_o, .data_lines_oe, .data_lines_i(data_bus));
    lbm_mem_model #(.ACC_NS(100.0), .PWRUP_NS(PWRUP_CYC * 4.0)) u_mem (
        .sel_n, .strobe_n, .gate_n, .supply_ok, .addr_lines, .data_lines(data_bus), .mem_o, .mem_oe, .n_viol);
    // second port in lockstep, with late-strobe writes
    lbm_host #(.PWRUP_CYC(PWRUP_CYC), .SEL_CTRL(1'b0)) DUT_B (
        .clk_sys, .rst, .supply_ok, .pwr_down_req, .req_valid, .req_write, .req_addr, .req_wdata,
        .req_ready(), .rsp_valid(), .rsp_rdata(rsp_rdata_b), .pwr_down_ok(), .sel_n(sel_n_b),
        .strobe_n(strobe_n_b), .gate_n(gate_n_b), .addr_lines(addr_lines_b), .data_lines_o(data_lines_o_b),
        .data_lines_oe(data_lines_oe_b), .data_lines_i(data_bus_b));
    lbm_mem_model #(.ACC_NS(100.0), .PWRUP_NS(PWRUP_CYC * 4.0)) u_mem_b (
        .sel_n(sel_n_b), .strobe_n(strobe_n_b), .gate_n(gate_n_b), .supply_ok, .addr_lines(addr_lines_b),
        .data_lines(data_bus_b), .mem_o(mem_o_b), .mem_oe(mem_oe_b), .n_viol(n_viol_b));
    always #2 clk_sys = ~clk_sys;
    always @(posedge clk_sys) float_pat <= {float_pat[6:0], ~float_pat[7]};
    task chk_eq(input string what, input logic [8:0] exp, input logic [8:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task chk_min(input string what, input int lo, input int got);
        tests_run++;
        if (got < lo) begin
            n_fail++;
            $display("Error %s expected at least %0d seen %0d", what, lo, got);
        end
    endtask
    task give_verdict();
        if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic do_req(input logic w, input logic [8:0] a, input logic [7:0] d,
                          output logic [7:0] q, output int n_wait);
        int n_lat;
        @(negedge clk_sys);
        req_valid = 1'b1;
        req_write = w;
        req_addr = a;
        req_wdata = d;
        n_wait = 0;
        while (req_ready !== 1'b1 && n_wait < 400) begin
            @(negedge clk_sys);
            n_wait++;
        end
        chk_eq("request taken", 9'h001, {8'h00, req_ready});
        req_valid = 1'b0;
        n_lat = 0;
        while (rsp_valid !== 1'b1 && n_lat < 200) begin
            @(negedge clk_sys);
            n_lat++;
        end
        q = rsp_rdata;
        chk_eq("select active cycles", 9'h032, n_lat[8:0]);
    endtask
    task automatic t_powerup();
        logic [7:0] q;
        int         nw;
        fork
            begin
                repeat (5) @(negedge clk_sys);
                supply_ok = 1'b1;
            end
        join_none
        do_req(1'b1, 9'h000, 8'ha5, q, nw);
        chk_min("wait after supply up", PWRUP_CYC + 5, nw);
    endtask
    task automatic t_rw();
        logic [8:0] a [4] = '{9'h1ff, 9'h100, 9'h155, 9'h0aa};
        logic [7:0] q;
        int         nw;
        for (int i = 0; i < 4; i++) begin
            do_req(1'b1, a[i], a[i][7:0] ^ 8'h3c, q, nw);
            chk_min("recovery before next access", 49, nw);
        end
        for (int i = 0; i < 4; i++) begin
            do_req(1'b0, a[i], 8'h00, q, nw);
            chk_eq("read back", {1'b0, a[i][7:0] ^ 8'h3c}, {1'b0, q});
            chk_eq("late-strobe read back", {1'b0, a[i][7:0] ^ 8'h3c}, {1'b0, rsp_rdata_b});
        end
    endtask
    task automatic t_pwrdown();
        logic [7:0] q;
        int         nw, n;
        fork
            begin
                @(negedge clk_sys iff req_ready);
                repeat (10) @(negedge clk_sys);
                pwr_down_req = 1'b1;
            end
        join_none
        do_req(1'b1, 9'h0aa, 8'h77, q, nw);
        n = 0;
        while (pwr_down_ok !== 1'b1 && n < 400) begin
            @(negedge clk_sys);
            n++;
        end
        chk_eq("power-down grant", 9'h001, {8'h00, pwr_down_ok});
        chk_min("park delay after access", 50, n);
        chk_eq("select idle while parked", 9'h001, {8'h00, sel_n});
        supply_ok = 1'b0;
        pwr_down_req = 1'b0;
        repeat (20) @(negedge clk_sys);
        supply_ok = 1'b1;
        do_req(1'b0, 9'h0aa, 8'h00, q, nw);
        chk_min("wait after supply returns", PWRUP_CYC, nw);
        chk_eq("byte kept over power cycle", 9'h077, {1'b0, q});
        do_req(1'b0, 9'h000, 8'h00, q, nw);
        chk_eq("first written byte", 9'h0a5, {1'b0, q});
    endtask
    initial begin
        clk_sys = 1'b0;
        rst = 1'b1;
        supply_ok = 1'b0;
        pwr_down_req = 1'b0;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr = 9'h000;
        req_wdata = 8'h00;
        float_pat = 8'h00;
        n_fail = 0;
        tests_run = 0;
        repeat (8) @(negedge clk_sys);
        rst = 1'b0;
        t_powerup();
        t_rw();
        t_pwrdown();
        repeat (60) @(negedge clk_sys);
        chk_eq("memory protocol faults", 9'h000, n_viol[8:0]);
        chk_eq("late-strobe protocol faults", 9'h000, n_viol_b[8:0]);
        give_verdict();
    end
    // watchdog, about fifteen times the expected run
    initial begin
        #80000;
        n_fail++;
        give_verdict();
    end
endmodule
